// >>> verilog/gpr_regs.sv
/*
 top of the gigabit role, status, indirect access and extended status registers.
 assumes a management frame engine gives one-cycle regWr/regRd strobes with a 5-bit register
 index; read data is captured on the read strobe and shown on rdData the next cycle.
 device address and register address sent out with the write strobe describe the indirect write
 reaching the manageable device space; a read strobe under function 10 goes out with the next address.
*/
`timescale 1ns/10ps
`include "gpr_defines.svh"
module gpr_regs (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] wrData,
   input wire logic roleFault,
   input wire logic resolvedMaster,
   input wire logic localRxOk,
   input wire logic remoteRxOk,
   input wire logic partnerFull,
   input wire logic partnerHalf,
   input wire logic idleError,
   input wire logic autoMaster,
   input wire logic [15:0] mmdRdData,
   output logic [15:0] rdData,
   output logic [2:0] testMode,
   output logic useMaster,
   output logic multiPort,
   output logic advFull,
   output logic advHalf,
   output logic [4:0] targetDeviceNumber,
   output logic [15:0] mmdAddress,
   output logic mmdWrite,
   output logic mmdRead,
   output logic [15:0] mmdWrData
);
   logic [15:0] roleCtl;
   logic faultLatch;
   logic [7:0] errCount;
   logic [15:0] indCtlValue;
   logic [15:0] indDataValue;
   logic [4:0] devNum;
   logic [15:0] regAddress;
   logic indWrite;
   logic indRead;
   logic [15:0] indWrData;

   // register selects
   wire logic selCtl = (regAddr == `GPR_OFS_ROLE_CTL);
   wire logic selSts = (regAddr == `GPR_OFS_ROLE_STS);
   wire logic selInd = (regAddr == `GPR_OFS_IND_CTL);
   wire logic selData = (regAddr == `GPR_OFS_IND_DATA);
   wire logic selExt = (regAddr == `GPR_OFS_EXT_STS);
   wire logic rdSts = regRd && selSts;

   // status word; the fault bit reads as latched or as a fault this very cycle
   wire logic [15:0] stsValue = {faultLatch | roleFault, resolvedMaster, localRxOk, remoteRxOk, // [RULE7] [RULE8] [RULE9] [RULE10]
                                 partnerFull, partnerHalf, 2'b00, errCount}; // [RULE11] [RULE21]

   // read mux; unmapped indices read zero
   wire logic [15:0] rdMux = selCtl ? roleCtl :
                             selSts ? stsValue :
                             selInd ? indCtlValue :
                             selData ? indDataValue :
                             selExt ? `GPR_EXT_VALUE : 16'h0000; // [RULE17] [RULE18]

   // only defined bits are writable, reserved bits stay zero
   wire logic [15:0] next_roleCtl = (regWr && selCtl) ? (wrData & `GPR_CTL_WMASK) : roleCtl; // [RULE21]

   // role choice: manual value only while manual enable is set
   wire logic next_useMaster = roleCtl[`GPR_MAN_EN] ? roleCtl[`GPR_MAN_VAL] : autoMaster; // [RULE2] [RULE3]

   // a new fault wins over the read that would clear it
   wire logic next_faultLatch = roleFault ? 1'b1 : (rdSts ? 1'b0 : faultLatch); // [RULE7]

   // control register and latched fault
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         roleCtl <= `GPR_CTL_RESET;
         faultLatch <= 1'b0;
      end else if (ce) begin
         roleCtl <= next_roleCtl;
         faultLatch <= next_faultLatch;
      end
   end

   // registered outputs toward the transceiver core
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         testMode <= gpr_pkg::GPR_TM_NORMAL;
         useMaster <= 1'b0;
         multiPort <= 1'b0;
         advFull <= 1'b1;
         advHalf <= 1'b0;
      end else if (ce) begin
         testMode <= roleCtl[`GPR_TM_HI:`GPR_TM_LO]; // [RULE1]
         useMaster <= next_useMaster;
         multiPort <= roleCtl[`GPR_PORT_TYPE]; // [RULE4]
         advFull <= roleCtl[`GPR_ADV_FULL]; // [RULE5]
         advHalf <= roleCtl[`GPR_ADV_HALF]; // passed through; host keeps it 0 [RULE6]
      end
   end

   // read data held until the next read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) rdData <= 16'h0000;
      else if (ce && regRd) rdData <= rdMux;
   end

   // indirect engine outputs retimed once more; the address is held while a write
   // strobe is out, since the engine has already stepped past it in increment modes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         targetDeviceNumber <= 5'h00;
         mmdAddress <= 16'h0000;
         mmdWrite <= 1'b0;
         mmdRead <= 1'b0;
         mmdWrData <= 16'h0000;
      end else if (ce) begin
         targetDeviceNumber <= devNum;
         if (!indWrite) mmdAddress <= regAddress; // [RULE16] [RULE19]
         mmdWrite <= indWrite;
         mmdRead <= indRead;
         mmdWrData <= indWrData;
      end
   end

   gpr_err_counter u_err (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .errPulse(idleError),
      .clearRd(rdSts), // [RULE12]
      .count(errCount)
   );

   gpr_indirect u_ind (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .ctlWr(regWr && selInd),
      .dataWr(regWr && selData),
      .dataRd(regRd && selData),
      .wrData(wrData),
      .mmdRdData(mmdRdData),
      .ctlValue(indCtlValue),
      .dataValue(indDataValue),
      .targetDeviceNumber(devNum),
      .regAddress(regAddress),
      .mmdWrite(indWrite),
      .mmdRead(indRead),
      .mmdWrData(indWrData)
   );
endmodule // gpr_regs

// >>> verilog/gpr_defines.svh
/*
 register map, field positions, reset values for the gigabit role and indirect access registers.
 assumes a management frame engine outside presents decoded register reads and writes.
*/
// How it works
// [RULE1] three-bit test mode selects transmitter pattern
// [RULE2] manual enable picks programmed role, else auto
// [RULE3] manual value: 1 master, 0 slave
// [RULE4] port type bit, multi or single, resets 0
// [RULE5] gigabit full duplex advertise bit resets 1
// [RULE6] host writes half duplex advertise as 0
// [RULE7] role fault flag latches high until read
// [RULE8] resolution bit shows resolved master or slave
// [RULE9] local receiver ok status bit
// [RULE10] remote receiver ok status bit
// [RULE11] partner full and half duplex abilities
// [RULE12] idle error counter saturates, clears on read
// [RULE13] function field: address, data, increment modes
// [RULE14] five-bit target device number, resets zero
// [RULE15] function 00 writes set register address
// [RULE16] data functions move data at stored address
// [RULE17] extended status: gigabit full 1, half 0
// [RULE18] extended status: no 1000BASE-X abilities
// [RULE19] increment modes advance address after access
// [RULE20] host sets address then data function
// [RULE21] reserved bits read zero, ignore writes
`ifndef GPR_DEFINES_SVH
`define GPR_DEFINES_SVH
`define GPR_OFS_ROLE_CTL 5'h09
`define GPR_OFS_ROLE_STS 5'h0a
`define GPR_OFS_IND_CTL 5'h0d
`define GPR_OFS_IND_DATA 5'h0e
`define GPR_OFS_EXT_STS 5'h0f
`define GPR_CTL_WMASK 16'hff00
`define GPR_CTL_RESET 16'h0200
`define GPR_IND_WMASK 16'hc01f
`define GPR_EXT_VALUE 16'h2000
`define GPR_TM_HI 15
`define GPR_TM_LO 13
`define GPR_MAN_EN 12
`define GPR_MAN_VAL 11
`define GPR_PORT_TYPE 10
`define GPR_ADV_FULL 9
`define GPR_ADV_HALF 8
`define GPR_FN_HI 15
`define GPR_FN_LO 14
`define GPR_DEV_HI 4
`define GPR_ERR_MAX 8'hff
`endif

// >>> verilog/gpr_pkg.sv
/*
 types shared by the register bank modules.
 assumes nothing beyond a SystemVerilog compiler.
*/
package gpr_pkg;
   // indirect access function codes
   typedef enum logic [1:0] {
      GPR_FN_ADDR = 2'h0,
      GPR_FN_DATA = 2'h1,
      GPR_FN_INC_RW = 2'h2,
      GPR_FN_INC_WR = 2'h3
   } gpr_fn_t;
   // transmitter test modes; 5..7 reserved
   typedef enum logic [2:0] {
      GPR_TM_NORMAL = 3'h0,
      GPR_TM_WAVEFORM = 3'h1,
      GPR_TM_JIT_MASTER = 3'h2,
      GPR_TM_JIT_SLAVE = 3'h3,
      GPR_TM_DISTORT = 3'h4
   } gpr_test_t;
endpackage

// >>> verilog/gpr_err_counter.sv
/*
 saturating eight-bit idle error counter, cleared by a read.
 assumes error pulses are synchronous to clk.
*/
`timescale 1ns/10ps
`include "gpr_defines.svh"
module gpr_err_counter (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic errPulse,
   input wire logic clearRd,
   output logic [7:0] count
);
   wire logic atMax = (count == `GPR_ERR_MAX);
   // an error in the clearing cycle counts as one, so it is not lost
   wire logic [7:0] next_count = clearRd ? {7'h00, errPulse} :
                                 ((errPulse && !atMax) ? count + 8'h01 : count); // [RULE12]
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) count <= 8'h00;
      else if (ce) count <= next_count;
   end
endmodule // gpr_err_counter

// >>> verilog/gpr_indirect.sv
/*
 indirect access engine: function/device control, stored register address, data path to the
 manageable device space. assumes the device space answers reads combinationally on mmdRdData.
*/
`timescale 1ns/10ps
`include "gpr_defines.svh"
module gpr_indirect (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic ctlWr,
   input wire logic dataWr,
   input wire logic dataRd,
   input wire logic [15:0] wrData,
   input wire logic [15:0] mmdRdData,
   output logic [15:0] ctlValue,
   output logic [15:0] dataValue,
   output logic [4:0] targetDeviceNumber,
   output logic [15:0] regAddress,
   output logic mmdWrite,
   output logic mmdRead,
   output logic [15:0] mmdWrData
);
   gpr_pkg::gpr_fn_t fn;
   wire logic isAddr = (fn == gpr_pkg::GPR_FN_ADDR);
   // post increment after reads only in mode 10, after writes in 10 and 11
   wire logic incOnWr = dataWr && (fn == gpr_pkg::GPR_FN_INC_RW || fn == gpr_pkg::GPR_FN_INC_WR); // [RULE19]
   wire logic incOnRd = dataRd && (fn == gpr_pkg::GPR_FN_INC_RW); // [RULE19]
   wire logic [15:0] next_regAddress = (dataWr && isAddr) ? wrData : // [RULE15]
                                       ((incOnWr || incOnRd) ? regAddress + 16'h0001 : regAddress);
   assign ctlValue = {fn, 9'h000, targetDeviceNumber}; // [RULE21]
   // data reads show the device space at the stored address, or the stored address itself under function 00
   assign dataValue = isAddr ? regAddress : mmdRdData; // [RULE16]
   // control register, address, and one-cycle device strobes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fn <= gpr_pkg::GPR_FN_ADDR;
         targetDeviceNumber <= 5'h00;
         regAddress <= 16'h0000;
         mmdWrite <= 1'b0;
         mmdRead <= 1'b0;
         mmdWrData <= 16'h0000;
      end else if (ce) begin
         if (ctlWr) begin
            fn <= gpr_pkg::gpr_fn_t'(wrData[`GPR_FN_HI:`GPR_FN_LO]); // [RULE13]
            targetDeviceNumber <= wrData[`GPR_DEV_HI:0]; // [RULE14]
         end
         regAddress <= next_regAddress;
         mmdWrite <= dataWr && !isAddr; // [RULE16]
         mmdRead <= dataRd && !isAddr;
         if (dataWr && !isAddr) mmdWrData <= wrData;
      end
   end
endmodule // gpr_indirect

// >>> verif/gpr_mmd_model.sv
/*
 small manageable device space behind the indirect access port.
 assumes mmd* strobes from gpr_regs; answers reads combinationally.
*/
`timescale 1ns/10ps
module gpr_mmd_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] targetDeviceNumber,
   input wire logic [15:0] mmdAddress,
   input wire logic mmdWrite,
   input wire logic [15:0] mmdWrData,
   output logic [15:0] mmdRdData
);
   logic [15:0] mem [64];
   // folded index: two device bits, four address bits, enough for the bench
   wire [5:0] idx = {targetDeviceNumber[1:0], mmdAddress[3:0]};
   assign mmdRdData = mem[idx];
   // reset fills each word with its own index so stale reads show
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 64; i++) mem[i] <= {10'h000, i[5:0]};
      end else if (mmdWrite) begin
         mem[idx] <= mmdWrData;
      end
   end
endmodule // gpr_mmd_model

// >>> verif/gpr_regs_chk.sv
/*
 port assertions for the role and indirect access registers.
 assumes binding to gpr_regs with ce held high during traffic.
*/
`timescale 1ns/10ps
module gpr_regs_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] wrData,
   input wire logic roleFault,
   input wire logic resolvedMaster,
   input wire logic localRxOk,
   input wire logic remoteRxOk,
   input wire logic partnerFull,
   input wire logic partnerHalf,
   input wire logic [15:0] rdData,
   input wire logic [2:0] testMode,
   input wire logic multiPort,
   input wire logic advFull,
   input wire logic advHalf,
   input wire logic mmdWrite,
   input wire logic mmdRead,
   input wire logic [15:0] mmdAddress
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // decoded strobes per register
   wire rdCtl = ce && regRd && regAddr == 5'h09;
   wire rdSts = ce && regRd && regAddr == 5'h0a;
   wire rdExt = ce && regRd && regAddr == 5'h0f;
   wire rdInd = ce && regRd && regAddr == 5'h0e;
   wire wrInd = ce && regWr && regAddr == 5'h0e;
   wire wrCtl = ce && regWr && regAddr == 5'h09;
   wire [5:0] ctlBits = {wrData[15:13], wrData[10:8]};
   chk_ctl_reserved: assert property (rdCtl |=> rdData[7:0] == 8'h00)
      else $error("role control low byte not zero");
   chk_ext_value: assert property (rdExt |=> rdData == 16'h2000)
      else $error("extended status wrong");
   chk_sts_resolve: assert property (rdSts |=> rdData[14] == $past(resolvedMaster))
      else $error("resolution bit wrong");
   chk_sts_rx_ok: assert property (rdSts |=> rdData[13:12] == {$past(localRxOk), $past(remoteRxOk)})
      else $error("receiver status wrong");
   chk_sts_partner: assert property (rdSts |=> rdData[11:8] == {$past(partnerFull), $past(partnerHalf), 2'b00})
      else $error("partner ability wrong");
   chk_fault_seen: assert property (rdSts && roleFault |=> rdData[15])
      else $error("fault not reported");
   chk_ctl_outputs: assert property (wrCtl |-> ##2 {testMode, multiPort, advFull, advHalf} == $past(ctlBits, 2))
      else $error("control outputs not updated");
   chk_wr_pulse: assert property (mmdWrite |-> $past(wrInd, 2))
      else $error("stray device write");
   chk_rd_pulse: assert property (mmdRead |-> $past(rdInd, 2))
      else $error("stray device read");
   chk_wr_addr_hold: assert property (mmdWrite |-> mmdAddress == $past(mmdAddress))
      else $error("device write address moved");
   cover property (wrInd ##2 mmdWrite);
   cover property (rdInd ##2 mmdRead);
   cover property (rdSts && roleFault);
endmodule // gpr_regs_chk
bind gpr_regs gpr_regs_chk u_chk (.clk(clk), .rst_b(rst_b), .ce(ce), .regWr(regWr), .regRd(regRd),
   .regAddr(regAddr), .wrData(wrData), .roleFault(roleFault), .resolvedMaster(resolvedMaster),
   .localRxOk(localRxOk), .remoteRxOk(remoteRxOk), .partnerFull(partnerFull), .partnerHalf(partnerHalf),
   .rdData(rdData), .testMode(testMode), .multiPort(multiPort), .advFull(advFull), .advHalf(advHalf),
   .mmdWrite(mmdWrite), .mmdRead(mmdRead), .mmdAddress(mmdAddress));

// >>> verif/tb_gigabit_phy_msctl_mmd_regs.sv
/*
 register level bench for gpr_regs with a device space model.
 assumes strobe handshake of gpr_regs; ce is held high except in one freeze test.
*/
`timescale 1ns/10ps
module tb_gigabit_phy_msctl_mmd_regs;
   logic clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, ce = 1'b1;
   logic [4:0] regAddr = 5'h00;
   logic [15:0] wrData = 16'h0000;
   logic roleFault = 0, resolvedMaster = 0, localRxOk = 0, remoteRxOk = 0;
   logic partnerFull = 0, partnerHalf = 0, idleError = 0, autoMaster = 0;
   logic [15:0] rdData, mmdRdData, mmdAddress, mmdWrData;
   logic [2:0] testMode;
   logic [4:0] targetDeviceNumber;
   logic useMaster, multiPort, advFull, advHalf, mmdWrite, mmdRead;
   logic [3:0] roleCase [4] = '{4'b1101, 4'b0100, 4'b1010, 4'b0011};
   int failCount = 0;
   int checksDone = 0;
   always #2.5 clk = ~clk;
   gpr_regs dut (.clk, .rst_b, .ce, .regWr, .regRd, .regAddr, .wrData, .roleFault, .resolvedMaster,
      .localRxOk, .remoteRxOk, .partnerFull, .partnerHalf, .idleError, .autoMaster, .mmdRdData, .rdData,
      .testMode, .useMaster, .multiPort, .advFull, .advHalf, .targetDeviceNumber, .mmdAddress, .mmdWrite,
      .mmdRead, .mmdWrData);
   gpr_mmd_model u_mmd (.clk, .rst_b, .targetDeviceNumber, .mmdAddress, .mmdWrite, .mmdWrData, .mmdRdData);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failCount++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // write strobe, then idle long enough for the device space pulse to land
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      wrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
      #1 chk(rdData, exp);
      repeat (2) @(posedge clk);
   endtask
   task automatic finalReport();
      if (failCount == 0 && checksDone > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd(5'h09, 16'h0200);
      rd(5'h0d, 16'h0000);
      rd(5'h0e, 16'h0000);
      rd(5'h0f, 16'h2000);
      rd(5'h03, 16'h0000);
      // every defined test mode, half duplex advertise left at 0
      for (int m = 0; m < 5; m++) begin
         wr(5'h09, {m[2:0], 13'h0200});
         chk({13'h0000, testMode}, {13'h0000, m[2:0]});
      end
      // manual enable, manual value, automatic role
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         autoMaster <= roleCase[k][1];
         wr(5'h09, {3'h0, roleCase[k][3:2], 11'h600});
         chk({15'h0000, useMaster}, {15'h0000, roleCase[k][0]});
      end
      chk({13'h0000, multiPort, advFull, advHalf}, 16'h0006);
      wr(5'h09, 16'h1eff);
      rd(5'h09, 16'h1e00);
      wr(5'h09, 16'h0000);
      chk({14'h0000, multiPort, advFull}, 16'h0000);
      // clock enable low drops a write and freezes the outputs
      @(posedge clk);
      ce <= 1'b0;
      wr(5'h09, 16'he400);
      @(posedge clk);
      ce <= 1'b1;
      chk({12'h000, testMode, multiPort}, 16'h0000);
      rd(5'h09, 16'h0000);
      // fault and three idle errors before one status read
      @(posedge clk);
      {resolvedMaster, localRxOk, partnerFull, roleFault, idleError} <= 5'h1f;
      repeat (3) @(posedge clk);
      {roleFault, idleError} <= 2'b00;
      rd(5'h0a, 16'he803);
      rd(5'h0a, 16'h6800);
      @(posedge clk);
      idleError <= 1'b1;
      repeat (300) @(posedge clk);
      {idleError, resolvedMaster, remoteRxOk, partnerHalf} <= 4'h3;
      rd(5'h0a, 16'h3cff);
      rd(5'h0a, 16'h3c00);
      // address phase, then each data function
      wr(5'h0d, 16'h0003);
      wr(5'h0e, 16'h0005);
      wr(5'h0d, 16'h4003);
      wr(5'h0e, 16'hbeef);
      rd(5'h0e, 16'hbeef);
      rd(5'h0e, 16'hbeef);
      chk(mmdAddress, 16'h0005);
      chk({11'h000, targetDeviceNumber}, 16'h0003);
      wr(5'h0d, 16'h8003);
      rd(5'h0e, 16'hbeef);
      rd(5'h0e, 16'h0036);
      wr(5'h0d, 16'hc003);
      wr(5'h0e, 16'h1111);
      rd(5'h0e, 16'h0038);
      rd(5'h0e, 16'h0038);
      wr(5'h0d, 16'h0003);
      rd(5'h0e, 16'h0008);
      wr(5'h0e, 16'h0007);
      wr(5'h0d, 16'h4003);
      rd(5'h0e, 16'h1111);
      wr(5'h0d, 16'hffff);
      rd(5'h0d, 16'hc01f);
      finalReport();
   end
   // whole run is well under 2000 cycles
   initial begin
      #100000;
      failCount++;
      finalReport();
   end
endmodule // tb_gigabit_phy_msctl_mmd_regs
